/* hw/cpu_ctl_map.svh */
// Purpose: Named constants of the control and pair arithmetic core
// Assumes: One T-state per CLOCK cycle
// Notes:   Included by its bare name
`ifndef CPU_CTL_MAP_SVH
`define CPU_CTL_MAP_SVH
// ----------------------------------------
// Flag positions
// ----------------------------------------
`define FL_C  0
`define FL_N  1
`define FL_PV 2
`define FL_H  4
`define FL_Z  6
`define FL_S  7
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OP_IDLE   8'h00
`define OP_BCD    8'h27
`define OP_INV    8'h2F
`define OP_CFORCE 8'h37
`define OP_CFLIP  8'h3F
`define OP_STOP   8'h76
`define OP_MASK   8'hF3
`define OP_UNMASK 8'hFB
`define PFX_EXT   8'hED
`define PFX_IXA   8'hDD
`define PFX_IXB   8'hFD
`define OP_NEG    8'h44
`define OP_IM0    8'h46
`define OP_IM1    8'h56
`define OP_IM2    8'h5E
`define OP_XINC   8'h23
`define OP_XDEC   8'h2B
// ----------------------------------------
// Clock states per operation
// ----------------------------------------
`define T_4   4'h4
`define T_6   4'h6
`define T_8   4'h8
`define T_10  4'hA
`define T_11  4'hB
`define T_15  4'hF
`define T_FETCH2 4'h4
`define T_HALT_LAST 4'h3
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define R_CTRL 8'h00
`define R_STAT 8'h04
`define R_AF   8'h08
`define R_BC   8'h0C
`define R_DE   8'h10
`define R_HL   8'h14
`define R_SP   8'h18
`define R_IX   8'h1C
`define R_IY   8'h20
`define R_PC   8'h24
// ----------------------------------------
// BCD correction
// ----------------------------------------
`define BCD_DMAX 4'h9
`define BCD_BMAX 8'h99
`define BCD_FIX  4'h6
`endif

/* hw/cpu_ctl_pkg.sv */
// Purpose: Types of the control and pair arithmetic core
// Assumes: Nothing
// Notes:   Constants live in cpu_ctl_map.svh
package cpu_ctl_pkg;
    typedef enum logic [1:0] {
        PH_STOP = 2'b00,
        PH_RUN  = 2'b01,
        PH_HALT = 2'b10
    } phase_t;

    typedef struct packed {
        phase_t      phase;
        logic        run;
        logic [7:0]  a;
        logic [7:0]  f;
        logic [15:0] bc;
        logic [15:0] de;
        logic [15:0] hl;
        logic [15:0] sp;
        logic [15:0] ix;
        logic [15:0] iy;
        logic [15:0] pc;
        logic        ie;
        logic [1:0]  im;
        logic [7:0]  op;
        logic [7:0]  op2;
        logic [3:0]  tcnt;
        logic [3:0]  len;
        logic        prog_rd;
        logic [15:0] prog_addr;
        logic        ack;
        logic [31:0] dat_o;
        logic        irq_s1;
        logic        irq_s2;
    } state_t;
endpackage

/* hw/cpu_ctl_core.sv */
// Purpose: Control, accumulator and register pair operations of an 8-bit core
// Assumes: Program memory holds the byte on PROG_DATA while PROG_RD is high
// Notes:   Registers reached over classic Wishbone
//
// What this block does
// - BCD adjust corrects accumulator, parity flag
// - Invert accumulator, set subtract and nibble-carry
// - Negate accumulator, overflow flag, eight states
// - Carry flip and carry force flag effects
// - Idle opcode zero changes nothing, four states
// - Stop opcode enters halted state
// - Mask clears, unmask sets interrupt latch
// - Extended prefix selects interrupt scheme 0-2
// - Add pair into memory pointer, eleven states
// - Add pair with carry into pointer
// - Subtract pair with borrow from pointer
// - Add pair into first index register
// - Add pair into second index register
// - Increment or decrement pair, six states
// - Increment or decrement index, ten states
// - Pair field picks first, second, third (the index itself under an index prefix), stack
// - Parity even or overflow gives one
`timescale 1ns/10ps
`include "cpu_ctl_map.svh"
module cpu_ctl_core (
    input  wire logic        CLOCK,
    input  wire logic        RESET,
    input  wire logic        WB_CYC,
    input  wire logic        WB_STB,
    input  wire logic        WB_WE,
    input  wire logic [7:0]  WB_ADR,
    input  wire logic [3:0]  WB_SEL,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK,
    output logic      [15:0] PROG_ADDR,
    output logic             PROG_RD,
    input  wire logic [7:0]  PROG_DATA,
    input  wire logic        IRQ,
    output logic             HALTED,
    output logic             IRQ_ENABLE
);
    cpu_ctl_pkg::state_t st;
    cpu_ctl_pkg::state_t n;
    logic                commit;
    logic [18:0]         r16;
    logic [15:0]         opd;
    logic [15:0]         x16;
    logic [7:0]          corr;
    logic [7:0]          r8;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic is_pfx(input logic [7:0] o);
        is_pfx = (o == `PFX_EXT) || (o == `PFX_IXA) || (o == `PFX_IXB);
    endfunction

    function automatic logic [3:0] op_len(input logic [7:0] o, input logic [7:0] o2,
                                          input logic sec);
        op_len = `T_4;
        if (!sec) begin
            if (is_pfx(o))
                op_len = `T_8;
            else if (o[7:6] == 2'b00 && o[3:0] == 4'h9)
                op_len = `T_11;
            else if (o[7:6] == 2'b00 && o[2:0] == 3'h3)
                op_len = `T_6;
        end else if (o == `PFX_EXT) begin
            op_len = (o2[7:6] == 2'b01 && o2[2:0] == 3'h2) ? `T_15 : `T_8;
        end else begin
            op_len = `T_8;
            if (o2 == `OP_XINC || o2 == `OP_XDEC)
                op_len = `T_10;
            else if (o2[7:6] == 2'b00 && o2[3:0] == 4'h9)
                op_len = `T_15;
        end
    endfunction

    function automatic logic [15:0] pick(input logic [1:0] s, input logic [15:0] p0,
                                         input logic [15:0] p1, input logic [15:0] p2,
                                         input logic [15:0] p3);
        unique case (s)
            2'h0: pick = p0;
            2'h1: pick = p1;
            2'h2: pick = p2;
            2'h3: pick = p3;
        endcase
    endfunction

    // {carry, nibble carry, overflow, result}
    function automatic logic [18:0] arith16(input logic [15:0] x, input logic [15:0] y,
                                            input logic cin, input logic sub);
        logic [15:0] yy;
        logic        ci;
        logic [16:0] s;
        logic [12:0] h;
        yy = sub ? ~y : y;
        ci = sub ? ~cin : cin;
        s  = {1'b0, x} + {1'b0, yy} + {16'h0000, ci};
        h  = {1'b0, x[11:0]} + {1'b0, yy[11:0]} + {12'h000, ci};
        arith16 = {s[16] ^ sub, h[12] ^ sub, (x[15] == yy[15]) && (s[15] != x[15]), s[15:0]};
    endfunction

    function automatic logic [15:0] lane16(input logic [15:0] old, input logic [15:0] d,
                                           input logic [1:0] sel);
        lane16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        n           = st;
        commit      = 1'b0;
        r16         = '0;
        opd         = '0;
        x16         = '0;
        corr        = '0;
        r8          = '0;
        n.irq_s1    = IRQ;
        n.irq_s2    = st.irq_s1;
        n.prog_rd   = 1'b0;
        n.ack       = 1'b0;

        // Register access; pairs writable only while stopped to avoid racing the core
        if (WB_CYC && WB_STB && !st.ack) begin
            n.ack = 1'b1;
            unique case (WB_ADR)
                `R_CTRL: n.dat_o = {31'h0000_0000, st.run};
                `R_STAT: n.dat_o = {24'h00_0000, 2'b00, st.im, 1'b0, st.ie, st.phase};
                `R_AF:   n.dat_o = {16'h0000, st.a, st.f};
                `R_BC:   n.dat_o = {16'h0000, st.bc};
                `R_DE:   n.dat_o = {16'h0000, st.de};
                `R_HL:   n.dat_o = {16'h0000, st.hl};
                `R_SP:   n.dat_o = {16'h0000, st.sp};
                `R_IX:   n.dat_o = {16'h0000, st.ix};
                `R_IY:   n.dat_o = {16'h0000, st.iy};
                `R_PC:   n.dat_o = {16'h0000, st.pc};
                default: n.dat_o = 32'h0000_0000;
            endcase
            if (WB_WE && WB_ADR == `R_CTRL && WB_SEL[0])
                n.run = WB_DAT_I[0];
            if (WB_WE && st.phase == cpu_ctl_pkg::PH_STOP && st.tcnt == 4'h0) begin
                unique case (WB_ADR)
                    `R_AF:   {n.a, n.f} = lane16({st.a, st.f}, WB_DAT_I[15:0], WB_SEL[1:0]);
                    `R_BC:   n.bc = lane16(st.bc, WB_DAT_I[15:0], WB_SEL[1:0]);
                    `R_DE:   n.de = lane16(st.de, WB_DAT_I[15:0], WB_SEL[1:0]);
                    `R_HL:   n.hl = lane16(st.hl, WB_DAT_I[15:0], WB_SEL[1:0]);
                    `R_SP:   n.sp = lane16(st.sp, WB_DAT_I[15:0], WB_SEL[1:0]);
                    `R_IX:   n.ix = lane16(st.ix, WB_DAT_I[15:0], WB_SEL[1:0]);
                    `R_IY:   n.iy = lane16(st.iy, WB_DAT_I[15:0], WB_SEL[1:0]);
                    `R_PC:   n.pc = lane16(st.pc, WB_DAT_I[15:0], WB_SEL[1:0]);
                    default: n.run = n.run;
                endcase
            end
        end

        unique case (st.phase)
            cpu_ctl_pkg::PH_HALT: begin
                // Idle loops of four states, no fetch, until an accepted interrupt
                n.tcnt = (st.tcnt == `T_HALT_LAST) ? 4'h0 : st.tcnt + 4'h1;
                if (st.tcnt == `T_HALT_LAST && st.irq_s2 && st.ie)
                    n.phase = cpu_ctl_pkg::PH_RUN;
            end
            default: begin
                if (st.tcnt == 4'h0)
                    n.phase = st.run ? cpu_ctl_pkg::PH_RUN : cpu_ctl_pkg::PH_STOP;
                if (st.tcnt != 4'h0 || st.run) begin
                    n.tcnt = st.tcnt + 4'h1;
                    if (st.tcnt == 4'h0) begin
                        n.prog_rd   = 1'b1;
                        n.prog_addr = st.pc;
                    end
                    if (st.tcnt == 4'h1) begin
                        n.op  = PROG_DATA;
                        n.len = op_len(PROG_DATA, 8'h00, 1'b0);
                    end
                    if (st.tcnt == `T_FETCH2 && is_pfx(st.op)) begin
                        n.prog_rd   = 1'b1;
                        n.prog_addr = st.pc + 16'h0001;
                    end
                    if (st.tcnt == `T_FETCH2 + 4'h1 && is_pfx(st.op)) begin
                        n.op2 = PROG_DATA;
                        n.len = op_len(st.op, PROG_DATA, 1'b1);
                    end
                    if (st.tcnt > 4'h1 && st.tcnt == st.len - 4'h1)
                        commit = 1'b1;
                end
            end
        endcase

        // ----------------------------------------
        // Execute at the last state
        // ----------------------------------------
        if (commit) begin
            n.tcnt = 4'h0;
            n.pc   = st.pc + (is_pfx(st.op) ? 16'h0002 : 16'h0001);
            if (st.op == `PFX_EXT) begin
                if (st.op2 == `OP_NEG) begin
                    r8 = 8'h00 - st.a;
                    n.a = r8;
                    n.f[`FL_C]  = st.a != 8'h00;
                    n.f[`FL_Z]  = r8 == 8'h00;
                    n.f[`FL_S]  = r8[7];
                    n.f[`FL_H]  = st.a[3:0] != 4'h0;
                    n.f[`FL_PV] = st.a == 8'h80;
                    n.f[`FL_N]  = 1'b1;
                end else if (st.op2 == `OP_IM0) begin
                    n.im = 2'h0;
                end else if (st.op2 == `OP_IM1) begin
                    n.im = 2'h1;
                end else if (st.op2 == `OP_IM2) begin
                    n.im = 2'h2;
                end else if (st.op2[7:6] == 2'b01 && st.op2[2:0] == 3'h2) begin
                    opd = pick(st.op2[5:4], st.bc, st.de, st.hl, st.sp);
                    r16 = arith16(st.hl, opd, st.f[`FL_C], ~st.op2[3]);
                    n.hl = r16[15:0];
                    n.f[`FL_C]  = r16[18];
                    n.f[`FL_H]  = r16[17];
                    n.f[`FL_PV] = r16[16];
                    n.f[`FL_Z]  = r16[15:0] == 16'h0000;
                    n.f[`FL_S]  = r16[15];
                    n.f[`FL_N]  = ~st.op2[3];
                end
            end else if (is_pfx(st.op)) begin
                x16 = (st.op == `PFX_IXA) ? st.ix : st.iy;
                if (st.op2 == `OP_XINC)
                    x16 = x16 + 16'h0001;
                else if (st.op2 == `OP_XDEC)
                    x16 = x16 - 16'h0001;
                else if (st.op2[7:6] == 2'b00 && st.op2[3:0] == 4'h9) begin
                    opd = pick(st.op2[5:4], st.bc, st.de, x16, st.sp);
                    r16 = arith16(x16, opd, 1'b0, 1'b0);
                    x16 = r16[15:0];
                    n.f[`FL_C] = r16[18];
                    n.f[`FL_H] = r16[17];
                    n.f[`FL_N] = 1'b0;
                end
                if (st.op == `PFX_IXA)
                    n.ix = x16;
                else
                    n.iy = x16;
            end else begin
                unique case (st.op)
                    `OP_BCD: begin
                        n.f[`FL_C] = st.f[`FL_C];
                        if (st.f[`FL_H] || st.a[3:0] > `BCD_DMAX)
                            corr[3:0] = `BCD_FIX;
                        if (st.f[`FL_C] || st.a > `BCD_BMAX) begin
                            corr[7:4] = `BCD_FIX;
                            n.f[`FL_C] = 1'b1;
                        end
                        r8 = st.f[`FL_N] ? st.a - corr : st.a + corr;
                        n.a = r8;
                        n.f[`FL_H]  = st.f[`FL_N] ? (st.f[`FL_H] && st.a[3:0] < `BCD_FIX)
                                                  : (st.a[3:0] > `BCD_DMAX);
                        n.f[`FL_Z]  = r8 == 8'h00;
                        n.f[`FL_S]  = r8[7];
                        n.f[`FL_PV] = ~^r8;
                    end
                    `OP_INV: begin
                        n.a = ~st.a;
                        n.f[`FL_N] = 1'b1;
                        n.f[`FL_H] = 1'b1;
                    end
                    `OP_CFLIP: begin
                        n.f[`FL_H] = st.f[`FL_C];
                        n.f[`FL_C] = ~st.f[`FL_C];
                        n.f[`FL_N] = 1'b0;
                    end
                    `OP_CFORCE: begin
                        n.f[`FL_C] = 1'b1;
                        n.f[`FL_N] = 1'b0;
                        n.f[`FL_H] = 1'b0;
                    end
                    `OP_STOP:   n.phase = cpu_ctl_pkg::PH_HALT;
                    `OP_MASK:   n.ie = 1'b0;
                    `OP_UNMASK: n.ie = 1'b1;
                    default: begin
                        // Opcode zero and anything outside this group fall through idle
                        opd = pick(st.op[5:4], st.bc, st.de, st.hl, st.sp);
                        if (st.op[7:6] == 2'b00 && st.op[3:0] == 4'h9) begin
                            r16 = arith16(st.hl, opd, 1'b0, 1'b0);
                            n.hl = r16[15:0];
                            n.f[`FL_C] = r16[18];
                            n.f[`FL_H] = r16[17];
                            n.f[`FL_N] = 1'b0;
                        end else if (st.op[7:6] == 2'b00 && st.op[2:0] == 3'h3) begin
                            x16 = st.op[3] ? opd - 16'h0001 : opd + 16'h0001;
                            unique case (st.op[5:4])
                                2'h0: n.bc = x16;
                                2'h1: n.de = x16;
                                2'h2: n.hl = x16;
                                2'h3: n.sp = x16;
                            endcase
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET)
            st <= '0;
        else
            st <= n;
    end

    assign WB_DAT_O   = st.dat_o;
    assign WB_ACK     = st.ack;
    assign PROG_ADDR  = st.prog_addr;
    assign PROG_RD    = st.prog_rd;
    assign HALTED     = st.phase[1]; // Halt is the only phase code with its top bit set
    assign IRQ_ENABLE = st.ie;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    idle_len_a: assert property (commit && st.op == `OP_IDLE |-> st.len == `T_4 ##1
        st.a == $past(st.a) && st.f == $past(st.f) && st.hl == $past(st.hl))
        else $error("idle op length or state wrong");
    invert_acc_a: assert property (commit && st.op == `OP_INV |=> st.a == ~$past(st.a)
        && st.f[`FL_N] && st.f[`FL_H]) else $error("invert result wrong");
    negate_acc_a: assert property (commit && st.op == `PFX_EXT && st.op2 == `OP_NEG
        |-> st.len == `T_8 ##1 st.a == 8'h00 - $past(st.a) && st.f[`FL_N])
        else $error("negate result wrong");
    carry_force_a: assert property (commit && st.op == `OP_CFORCE |=> st.f[`FL_C]
        && !st.f[`FL_N] && !st.f[`FL_H]) else $error("carry force wrong");
    halt_hold_a: assert property (st.phase == cpu_ctl_pkg::PH_HALT |=> !st.prog_rd
        && st.pc == $past(st.pc)) else $error("halted core moved");
    irq_mask_a: assert property (commit && st.op == `OP_MASK |=> !st.ie[*2])
        else $error("mask did not clear latch");
    scheme_sel_a: assert property (commit && st.op == `PFX_EXT && st.op2 == `OP_IM2
        |=> st.im == 2'h2 && st.f == $past(st.f)) else $error("scheme select wrong");
    pair_add_a: assert property (commit && st.op[7:6] == 2'b00 && st.op[3:0] == 4'h9
        |-> st.len == `T_11 ##1 !st.f[`FL_N]) else $error("pointer add wrong");
    pair_step_a: assert property (commit && st.op[7:6] == 2'b00 && st.op[2:0] == 3'h3
        |-> st.len == `T_6 ##1 st.f == $past(st.f)) else $error("pair step wrong");
endmodule

/* verif/prog_mem_model.sv */
// Purpose: Program memory partner that answers fetches of the core
// Assumes: The byte stands on the bus in the strobe cycle itself
// Notes:   Records the cycle of the latest fetch of each address
`timescale 1ns/10ps
module prog_mem_model (
    input  wire logic        CLOCK,
    input  wire logic        PROG_RD,
    input  wire logic [15:0] PROG_ADDR,
    output logic      [7:0]  PROG_DATA
);
    logic [7:0]  mem [256];
    int unsigned t_at [256];
    int unsigned cyc;
    int unsigned fetches;

    initial begin
        cyc = 0;
        fetches = 0;
    end

    // ----------------------------------------
    // Fetch answer
    // ----------------------------------------
    // No pull on the lines: inverse outside the strobe, so stale data never looks valid
    assign PROG_DATA = PROG_RD ? mem[PROG_ADDR[7:0]] : ~mem[PROG_ADDR[7:0]];

    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (PROG_RD) begin
            t_at[PROG_ADDR[7:0]] <= cyc;
            fetches <= fetches + 1;
        end
    end
endmodule

/* verif/cpu_ctl_core_tb.sv */
// Purpose: Self-checking bench of the control and pair arithmetic core
// Assumes: One clock state per CLOCK cycle
// Notes:   Every scenario starts from a fresh reset
`timescale 1ns/10ps
`include "cpu_ctl_map.svh"
module cpu_ctl_core_tb;
    logic        CLOCK = 1'b0;
    logic        RESET = 1'b1;
    logic        WB_CYC = 1'b0;
    logic        WB_STB = 1'b0;
    logic        WB_WE = 1'b0;
    logic [7:0]  WB_ADR = 8'h00;
    logic [3:0]  WB_SEL = 4'h3;
    logic [31:0] WB_DAT_I = 32'h0000_0000;
    logic [31:0] WB_DAT_O;
    logic        WB_ACK;
    logic [15:0] PROG_ADDR;
    logic        PROG_RD;
    logic [7:0]  PROG_DATA;
    logic        IRQ = 1'b0;
    logic        HALTED;
    logic        IRQ_ENABLE;
    int          num_errors = 0;
    int          cmp_count = 0;

    always #2.5 CLOCK = ~CLOCK;

    cpu_ctl_core u_dut (.CLOCK(CLOCK), .RESET(RESET), .WB_CYC(WB_CYC), .WB_STB(WB_STB),
        .WB_WE(WB_WE), .WB_ADR(WB_ADR), .WB_SEL(WB_SEL), .WB_DAT_I(WB_DAT_I),
        .WB_DAT_O(WB_DAT_O), .WB_ACK(WB_ACK), .PROG_ADDR(PROG_ADDR), .PROG_RD(PROG_RD),
        .PROG_DATA(PROG_DATA), .IRQ(IRQ), .HALTED(HALTED), .IRQ_ENABLE(IRQ_ENABLE));

    prog_mem_model u_mem (.CLOCK(CLOCK), .PROG_RD(PROG_RD), .PROG_ADDR(PROG_ADDR),
        .PROG_DATA(PROG_DATA));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        WB_CYC <= 1'b1;
        WB_STB <= 1'b1;
        WB_WE <= we;
        WB_ADR <= adr;
        WB_DAT_I <= d;
        do begin
            @(posedge CLOCK);
            n++;
        end while (WB_ACK !== 1'b1 && n < 50);
        q = WB_DAT_O;
        WB_CYC <= 1'b0;
        WB_STB <= 1'b0;
        if (WB_ACK !== 1'b1) chk("bus ack", 32'h0000_0000, 32'h0000_0001);
        @(posedge CLOCK);
    endtask

    task automatic chkreg(input string what, input logic [7:0] adr, input logic [15:0] mask,
                          input logic [15:0] exp);
        logic [31:0] q;
        wb(1'b0, adr, 32'h0000_0000, q);
        chk(what, q & {16'h0000, mask}, {16'h0000, exp});
    endtask

    task automatic do_reset();
        RESET <= 1'b1;
        repeat (16) @(posedge CLOCK);
        RESET <= 1'b0;
        @(posedge CLOCK);
    endtask

    task automatic wait_halt(input logic lvl, input int lim);
        int n;
        n = 0;
        while (HALTED !== lvl && n < lim) begin
            @(posedge CLOCK);
            n++;
        end
        chk("halted wait", {31'h0000_0000, HALTED}, {31'h0000_0000, lvl});
    endtask

    // Loads registers from AF upward, runs to the stop opcode, times each instruction before the stop opcode
    task automatic scen(input logic [7:0] p[$], input logic [15:0] v[$], input int len[$]);
        logic [31:0] q;
        int s;
        int n;
        do_reset();
        foreach (v[i]) wb(1'b1, `R_AF + 8'(4 * i), {16'h0000, v[i]}, q);
        for (int i = 0; i < 256; i++) u_mem.mem[i] = 8'h00;
        foreach (p[i]) u_mem.mem[i] = p[i];
        wb(1'b1, `R_CTRL, 32'h0000_0001, q);
        wait_halt(1'b1, 400);
        s = 0;
        foreach (len[i]) begin
            n = s + ((p[s] == `PFX_EXT || p[s] == `PFX_IXA || p[s] == `PFX_IXB) ? 2 : 1);
            chk("states", u_mem.t_at[n] - u_mem.t_at[s], len[i]);
            s = n;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        do_reset();
        chkreg("af reset", `R_AF, 16'hffff, 16'h0000);
        chkreg("stat reset", `R_STAT, 16'hffff, 16'h0000);
        chkreg("unmapped", 8'h3c, 16'hffff, 16'h0000);
    endtask

    task automatic t_acc();
        scen({8'h2f, 8'h37, 8'h3f, 8'h00, 8'h76}, {16'h3c00}, {4, 4, 4, 4});
        chkreg("acc flags", `R_AF, 16'hffff, 16'hc310);
    endtask

    task automatic t_bcd();
        scen({8'h27, 8'h76}, {16'h9a00}, {4});
        chkreg("bcd adjust", `R_AF, 16'hffff, 16'h0055);
        scen({8'hed, 8'h44, 8'h76}, {16'h8000}, {8});
        chkreg("negate", `R_AF, 16'hffff, 16'h8087);
    endtask

    task automatic t_pair();
        scen({8'h09, 8'h19, 8'h29, 8'h39, 8'h03, 8'h1b, 8'h23, 8'h3b, 8'h76},
             {16'h00c6, 16'h1234, 16'h0f00, 16'h8000, 16'h7fff}, {11, 11, 11, 11, 6, 6, 6, 6});
        chkreg("pair flags", `R_AF, 16'h00ef, 16'h00c4);
        chkreg("first pair", `R_BC, 16'hffff, 16'h1235);
        chkreg("second pair", `R_DE, 16'hffff, 16'h0eff);
        chkreg("pointer", `R_HL, 16'hffff, 16'hc268);
        chkreg("stack", `R_SP, 16'hffff, 16'h7ffe);
    endtask

    task automatic t_carry();
        scen({8'hed, 8'h4a, 8'hed, 8'h52, 8'h76},
             {16'h0001, 16'h0001, 16'h0002, 16'h7fff}, {15, 15});
        chkreg("pointer", `R_HL, 16'hffff, 16'h7fff);
        chkreg("borrow flags", `R_AF, 16'h00ef, 16'h0006);
    endtask

    task automatic t_index();
        scen({8'hdd, 8'h09, 8'hdd, 8'h19, 8'hdd, 8'h29, 8'hdd, 8'h39, 8'hfd, 8'h29,
              8'hfd, 8'h23, 8'hdd, 8'h2b, 8'h76},
             {16'h00c6, 16'h0001, 16'h0010, 16'h0005, 16'h0100, 16'h1000, 16'h2000},
             {15, 15, 15, 15, 15, 10, 10});
        chkreg("index one", `R_IX, 16'hffff, 16'h2121);
        chkreg("index two", `R_IY, 16'hffff, 16'h4001);
        chkreg("index flags", `R_AF, 16'h00ef, 16'h00c4);
    endtask

    task automatic t_scheme();
        logic [7:0] code [3] = '{`OP_IM0, `OP_IM1, `OP_IM2};
        for (int k = 0; k < 3; k++) begin
            scen({8'hed, code[k], 8'h76}, {16'h00d7}, {8});
            chkreg("scheme", `R_STAT, 16'h0030, 16'(k << 4));
            chkreg("scheme flags", `R_AF, 16'h00ff, 16'h00d7);
        end
    endtask

    task automatic t_halt();
        int unsigned n;
        scen({8'hfb, 8'hf3, 8'h76}, {16'h0000}, {4, 4});
        chk("latch", IRQ_ENABLE, 32'h0000_0000);
        scen({8'hf3, 8'hfb, 8'h76, 8'h00, 8'h76}, {16'h0000}, {4, 4});
        chk("latch", IRQ_ENABLE, 32'h0000_0001);
        chkreg("halt status", `R_STAT, 16'h0007, 16'h0006);
        n = u_mem.fetches;
        repeat (40) @(posedge CLOCK);
        chk("halt fetches", u_mem.fetches, n);
        IRQ <= 1'b1;
        wait_halt(1'b0, 40);
        IRQ <= 1'b0;
        wait_halt(1'b1, 40);
        chk("resume addr", PROG_ADDR, 32'h0000_0004);
    endtask

    initial begin
        repeat (20000) @(posedge CLOCK);
        num_errors++;
        finish_test();
    end

    initial begin
        t_reset();
        t_acc();
        t_bcd();
        t_pair();
        t_carry();
        t_index();
        t_scheme();
        t_halt();
        finish_test();
    end
endmodule
